// ===== design/psfr_status_fault_response.v
`timescale 1ns/100ps
`default_nettype none
`include "psfr_map.vh"

// Operation
// R1: summary byte bit 6 shows the supply-on request is inactive
// R2: summary overvoltage bit is output overvoltage fault OR comparator overvoltage
// R3: summary line undervolt bit mirrors the line undervoltage fault bit
// R4: summary bit 2 set on any temperature fault or warning
// R5: summary bit 1 set on communication, memory or logic fault
// R6: summary bit 0 set on any fault not shown in bits 7 to 1
// R7: word bit 15 set on any output voltage fault or warning
// R8: word bit 13 is the OR of all seven line input flags
// R9: word bit 12 set on any vendor flag in three vendor registers
// R10: power-good-not is a masked OR of output flags, pin inverted
// R11: word bit 8 set on any fault not covered by bits 15 to 1
// R12: output flags: overvolt fault, overvolt warning, undervolt warning, undervolt fault
// R13: line flags: overvolt fault, undervolt warning, undervolt fault
// R14: line below turnoff sets bit 3 and shuts the supply down
// R15: line overcurrent fault sets bit 2, warning sets bit 1
// R16: thermal flags: overtemp fault bit 7, overtemp warning bit 6
// R17: a set standard flag runs the action of its action register
// R18: action register: type bits 7:6, retry 5:3, delay 2:0
// R19: type 00 ignores the flag, supply keeps running
// R20: types 01 and 10 shut down, then retry per retry field
// R21: type 01 debounces the flag by the delay field, 10 does not
// R22: type 11 disables output until the flag clears, no soft start
// R23: every flag reads 1 while its bad condition is present
// R24: among concurrent faults the highest response type acts first
// R25: equal response types: smallest retry setting wins
// R26: delay unit and retry meaning are parameters of the block; here only the delay unit is, retry 7 (forever) is fixed by PSFR_RETRY_FOREVER
module psfr_status_fault_response #(
  parameter DELAY_UNIT_CYCLES = `PSFR_DELAY_UNIT_CYCLES
) (
  input wire clk,
  input wire resetn,
  input wire [7:0] reg_cmd,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg reg_rvalid,
  input wire supply_on_request,
  input wire sw_supply_on_request,
  input wire output_overvolt_fault,
  input wire output_overvolt_warning,
  input wire output_undervolt_warning,
  input wire output_undervolt_fault,
  input wire line_overvolt_fault,
  input wire line_undervolt_warning,
  input wire line_undervolt_fault,
  input wire line_below_turnoff,
  input wire line_overcurrent_fault,
  input wire line_overcurrent_warning,
  input wire line_overpower_warning,
  input wire overtemp_fault,
  input wire overtemp_warning,
  input wire comm_memory_logic_fault,
  input wire [7:0] vendor_flags_a,
  input wire [7:0] vendor_flags_b,
  input wire [7:0] vendor_flags_c,
  input wire [4:0] power_good_mask,
  output reg output_ok_pin,
  output reg output_enable,
  output reg soft_start,
  output reg [2:0] fault_state,
  output reg [2:0] active_fault
);

  // ----------------------------------------------------------------------
  // states of the response engine
  // ----------------------------------------------------------------------
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_SHUT = 3'h2;
  localparam [2:0] ST_DISABLED = 3'h3;
  localparam [2:0] ST_LATCHED = 3'h4;
  localparam [15:0] UNIT = DELAY_UNIT_CYCLES[15:0];

  // ----------------------------------------------------------------------
  // reset release and pin synchroniser
  // ----------------------------------------------------------------------
  reg rst_meta;
  reg rst_n;
  reg on_ff1;
  reg on_ff2;
  reg on_ff3;
  reg hw_on;

  // reset asserts at once, releases after two edges
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // on-request pin: change taken once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_ff1 <= 1'b0;
      on_ff2 <= 1'b0;
      on_ff3 <= 1'b0;
      hw_on <= 1'b0;
    end else begin
      on_ff1 <= supply_on_request;
      on_ff2 <= on_ff1;
      on_ff3 <= on_ff2;
      if (on_ff2 == on_ff3) begin
        hw_on <= on_ff3;
      end
    end
  end

  wire supply_on_request_inactive = ~(hw_on & sw_supply_on_request);

  // ----------------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------------
  reg [7:0] output_voltage_flags;
  reg [7:0] line_input_flags;
  reg [7:0] thermal_flags;
  reg cml_flag;
  reg [7:0] vendor_a;
  reg [7:0] vendor_b;
  reg [7:0] vendor_c;

  // capture condition flags, 1 means bad
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_voltage_flags <= 8'h00;
      line_input_flags <= 8'h00;
      thermal_flags <= 8'h00;
      cml_flag <= 1'b0;
      vendor_a <= 8'h00;
      vendor_b <= 8'h00;
      vendor_c <= 8'h00;
    end else begin
      output_voltage_flags <= {output_overvolt_fault, output_overvolt_warning,
        output_undervolt_warning, output_undervolt_fault, 4'h0}; // R12 R23
      line_input_flags <= {line_overvolt_fault, 1'b0, line_undervolt_warning,
        line_undervolt_fault, line_below_turnoff, line_overcurrent_fault,
        line_overcurrent_warning, line_overpower_warning}; // R13 R14 R15
      thermal_flags <= {overtemp_fault, overtemp_warning, 6'h00}; // R16
      cml_flag <= comm_memory_logic_fault;
      vendor_a <= vendor_flags_a;
      vendor_b <= vendor_flags_b;
      vendor_c <= vendor_flags_c;
    end
  end

  // ----------------------------------------------------------------------
  // summary bits
  // ----------------------------------------------------------------------
  wire comparator_overvolt_flag = vendor_a[`PSFR_VENDOR_A_CMP_OV];
  wire any_output_overvolt = output_voltage_flags[`PSFR_OUTPUT_OVERVOLT_FAULT] |
    comparator_overvolt_flag; // R2
  wire summary_line_undervolt = line_input_flags[`PSFR_LINE_UV_FAULT]; // R3
  wire summary_temp = thermal_flags[`PSFR_TEMP_OVERTEMP_FAULT] |
    thermal_flags[`PSFR_TEMP_OVERTEMP_WARNING]; // R4
  wire vendor_flag_summary = (|vendor_a) | (|vendor_b) | (|vendor_c); // R9
  wire summary_output = (|output_voltage_flags) | comparator_overvolt_flag; // R7
  wire summary_input = |line_input_flags; // R8

  // masked output-side flags; overvolt fault always counts
  wire power_good_not = output_voltage_flags[`PSFR_OUTPUT_OVERVOLT_FAULT] |
    (power_good_mask[`PSFR_PG_UV_FAULT] & output_voltage_flags[`PSFR_OUTPUT_UNDERVOLT_FAULT]) |
    (power_good_mask[`PSFR_PG_OV_WARN] & output_voltage_flags[`PSFR_OUTPUT_OVERVOLT_WARNING]) |
    (power_good_mask[`PSFR_PG_CMP_OV] & comparator_overvolt_flag) |
    (power_good_mask[`PSFR_PG_OPEN_LOOP] & vendor_a[`PSFR_VENDOR_A_OPEN_LOOP]) |
    (power_good_mask[`PSFR_PG_FAST_OC] & vendor_b[`PSFR_VENDOR_B_FAST_OC]); // R10

  // byte bit 0: faults outside bits 7 to 1
  wire other_byte_fault = output_voltage_flags[`PSFR_OUTPUT_OVERVOLT_WARNING] |
    output_voltage_flags[`PSFR_OUTPUT_UNDERVOLT_WARNING] |
    output_voltage_flags[`PSFR_OUTPUT_UNDERVOLT_FAULT] |
    line_input_flags[`PSFR_LINE_OV_FAULT] | line_input_flags[`PSFR_LINE_UV_WARN] |
    line_input_flags[`PSFR_LINE_LOW] | line_input_flags[`PSFR_LINE_OC_FAULT] |
    line_input_flags[`PSFR_LINE_OC_WARN] | line_input_flags[`PSFR_LINE_OP_WARN] |
    vendor_flag_summary; // R6

  wire [7:0] summary_flags_short = {1'b0, supply_on_request_inactive,
    any_output_overvolt, 1'b0, summary_line_undervolt, summary_temp,
    cml_flag, other_byte_fault}; // R1 R2 R3 R4 R5 R6

  // word bit 8: every source is already covered by bits 15 to 1
  wire unknown_fault = 1'b0; // R11

  wire [15:0] summary_flags_long = {summary_output, 1'b0, summary_input,
    vendor_flag_summary, power_good_not, 2'h0, unknown_fault,
    summary_flags_short}; // R7 R8 R9 R10 R11

  // ----------------------------------------------------------------------
  // fault action registers and register port
  // ----------------------------------------------------------------------
  reg [7:0] fault_action [0:`PSFR_NUM_FAULTS-1];
  reg [2:0] wr_slot;
  reg wr_hit;
  integer k;

  // command code to action slot
  always @* begin
    wr_hit = 1'b1;
    case (reg_cmd)
      `PSFR_CMD_OUT_OV_ACT: wr_slot = `PSFR_SLOT_OUT_OV;
      `PSFR_CMD_OUT_UV_ACT: wr_slot = `PSFR_SLOT_OUT_UV;
      `PSFR_CMD_OT_ACT: wr_slot = `PSFR_SLOT_OT;
      `PSFR_CMD_LINE_OV_ACT: wr_slot = `PSFR_SLOT_LINE_OV;
      `PSFR_CMD_LINE_UV_ACT: wr_slot = `PSFR_SLOT_LINE_UV;
      `PSFR_CMD_LINE_OC_ACT: wr_slot = `PSFR_SLOT_LINE_OC;
      default: begin
        wr_slot = 3'h0;
        wr_hit = 1'b0;
      end
    endcase
  end

  // writes to action registers; other codes ignored
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < `PSFR_NUM_FAULTS; k = k + 1) begin
        fault_action[k] <= `PSFR_ACT_RESET;
      end
    end else if (reg_wr && wr_hit) begin
      fault_action[wr_slot] <= reg_wdata; // R18
    end
  end

  // read answer one cycle after the strobe; unmapped reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (wr_hit) begin
          reg_rdata <= {8'h00, fault_action[wr_slot]};
        end else begin
          case (reg_cmd)
            `PSFR_CMD_SUMMARY_SHORT: reg_rdata <= {8'h00, summary_flags_short};
            `PSFR_CMD_SUMMARY_LONG: reg_rdata <= summary_flags_long;
            `PSFR_CMD_OUTPUT_FLAGS: reg_rdata <= {8'h00, output_voltage_flags};
            `PSFR_CMD_LINE_FLAGS: reg_rdata <= {8'h00, line_input_flags};
            `PSFR_CMD_THERMAL_FLAGS: reg_rdata <= {8'h00, thermal_flags};
            default: reg_rdata <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // per-flag qualification and debounce
  // ----------------------------------------------------------------------
  wire [`PSFR_NUM_FAULTS-1:0] raw_fault = {
    line_input_flags[`PSFR_LINE_OC_FAULT], line_input_flags[`PSFR_LINE_UV_FAULT],
    line_input_flags[`PSFR_LINE_OV_FAULT], thermal_flags[`PSFR_TEMP_OVERTEMP_FAULT],
    output_voltage_flags[`PSFR_OUTPUT_UNDERVOLT_FAULT], output_voltage_flags[`PSFR_OUTPUT_OVERVOLT_FAULT]};
  wire [`PSFR_NUM_FAULTS-1:0] qual_fault;

  genvar g;
  generate
    for (g = 0; g < `PSFR_NUM_FAULTS; g = g + 1) begin : deb
      wire [1:0] typ = fault_action[g][`PSFR_ACT_TYPE_HI:`PSFR_ACT_TYPE_LO];
      wire [2:0] dly = fault_action[g][`PSFR_ACT_DELAY_HI:`PSFR_ACT_DELAY_LO];
      wire [15:0] need = dly * UNIT; // R26
      reg [15:0] cnt;
      // counts while the flag stays set, restarts when it drops
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= 16'h0000;
        end else if (!raw_fault[g]) begin
          cnt <= 16'h0000;
        end else if (cnt < need) begin
          cnt <= cnt + 16'h0001;
        end
      end
      // type 00 never qualifies; 01 after debounce; 10 and 11 at once
      assign qual_fault[g] = raw_fault[g] && (typ != `PSFR_TYPE_IGNORE) &&
        ((typ != `PSFR_TYPE_RETRY_DEB) || (cnt >= need)); // R19 R21
    end
  endgenerate

  // ----------------------------------------------------------------------
  // priority among concurrent faults
  // ----------------------------------------------------------------------
  reg sel_valid;
  reg [2:0] sel_slot;
  reg [1:0] sel_type;
  reg [2:0] sel_retry;
  integer i;

  // highest type wins, ties go to the smaller retry setting
  always @* begin
    sel_valid = 1'b0;
    sel_slot = 3'h0;
    sel_type = `PSFR_TYPE_IGNORE;
    sel_retry = 3'h0;
    for (i = 0; i < `PSFR_NUM_FAULTS; i = i + 1) begin
      if (qual_fault[i] && (!sel_valid ||
          fault_action[i][`PSFR_ACT_TYPE_HI:`PSFR_ACT_TYPE_LO] > sel_type ||
          (fault_action[i][`PSFR_ACT_TYPE_HI:`PSFR_ACT_TYPE_LO] == sel_type &&
           fault_action[i][`PSFR_ACT_RETRY_HI:`PSFR_ACT_RETRY_LO] < sel_retry))) begin // R24 R25
        sel_valid = 1'b1;
        sel_slot = i[2:0];
        sel_type = fault_action[i][`PSFR_ACT_TYPE_HI:`PSFR_ACT_TYPE_LO];
        sel_retry = fault_action[i][`PSFR_ACT_RETRY_HI:`PSFR_ACT_RETRY_LO];
      end
    end
  end

  // ----------------------------------------------------------------------
  // response engine
  // ----------------------------------------------------------------------
  reg [15:0] wait_cnt;
  reg [2:0] retries_left;
  wire [2:0] act_delay =
    fault_action[active_fault][`PSFR_ACT_DELAY_HI:`PSFR_ACT_DELAY_LO];
  wire [2:0] act_retry =
    fault_action[active_fault][`PSFR_ACT_RETRY_HI:`PSFR_ACT_RETRY_LO];
  wire [15:0] act_wait = act_delay * UNIT;
  wire run_blocked = supply_on_request_inactive | line_input_flags[`PSFR_LINE_LOW];

  // shutdown, retry, disable and latch-off sequencing
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_state <= ST_OFF;
      active_fault <= 3'h0;
      wait_cnt <= 16'h0000;
      retries_left <= 3'h0;
      soft_start <= 1'b0;
    end else begin
      soft_start <= 1'b0;
      case (fault_state)
        ST_OFF: begin
          if (!run_blocked) begin
            fault_state <= ST_RUN;
            soft_start <= 1'b1;
          end
        end
        ST_RUN: begin
          if (run_blocked) begin
            fault_state <= ST_OFF; // R14
          end else if (sel_valid) begin // R17
            active_fault <= sel_slot;
            wait_cnt <= 16'h0000;
            if (sel_type == `PSFR_TYPE_DISABLE) begin
              fault_state <= ST_DISABLED; // R22
            end else begin
              fault_state <= ST_SHUT; // R20
              retries_left <= sel_retry;
            end
          end
        end
        ST_SHUT: begin
          if (supply_on_request_inactive) begin
            fault_state <= ST_OFF;
          end else if (wait_cnt < act_wait) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end else if (!raw_fault[active_fault]) begin
            fault_state <= ST_OFF; // R20
          end else if (act_retry == `PSFR_RETRY_FOREVER) begin
            wait_cnt <= 16'h0000;
          end else if (retries_left == 3'h0) begin
            fault_state <= ST_LATCHED; // R20
          end else begin
            retries_left <= retries_left - 3'h1;
            wait_cnt <= 16'h0000;
          end
        end
        ST_DISABLED: begin
          if (!raw_fault[active_fault]) begin
            fault_state <= ST_RUN; // R22
          end
        end
        ST_LATCHED: begin
          if (supply_on_request_inactive) begin
            fault_state <= ST_OFF;
          end
        end
        default: begin
          fault_state <= ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output drive and power-good pin
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_enable <= 1'b0;
      output_ok_pin <= 1'b0;
    end else begin
      output_enable <= (fault_state == ST_RUN) && !run_blocked &&
        !(sel_valid && sel_type != `PSFR_TYPE_IGNORE); // R19 R20 R22
      output_ok_pin <= ~power_good_not; // R10
    end
  end

endmodule
`default_nettype wire

// ===== shared/psfr_map.vh
`ifndef PSFR_MAP_VH
`define PSFR_MAP_VH

// ----
// command codes of the register map
// ----
`define PSFR_CMD_OUT_OV_ACT 8'h41
`define PSFR_CMD_OUT_UV_ACT 8'h45
`define PSFR_CMD_OT_ACT 8'h50
`define PSFR_CMD_LINE_OV_ACT 8'h56
`define PSFR_CMD_LINE_UV_ACT 8'h5A
`define PSFR_CMD_LINE_OC_ACT 8'h5C
`define PSFR_CMD_SUMMARY_SHORT 8'h78
`define PSFR_CMD_SUMMARY_LONG 8'h79
`define PSFR_CMD_OUTPUT_FLAGS 8'h7A
`define PSFR_CMD_LINE_FLAGS 8'h7C
`define PSFR_CMD_THERMAL_FLAGS 8'h7D

// ----
// fault action register fields and reset value
// ----
`define PSFR_ACT_TYPE_HI 7
`define PSFR_ACT_TYPE_LO 6
`define PSFR_ACT_RETRY_HI 5
`define PSFR_ACT_RETRY_LO 3
`define PSFR_ACT_DELAY_HI 2
`define PSFR_ACT_DELAY_LO 0
`define PSFR_ACT_RESET 8'h00

// response types
`define PSFR_TYPE_IGNORE 2'h0
`define PSFR_TYPE_RETRY_DEB 2'h1
`define PSFR_TYPE_RETRY 2'h2
`define PSFR_TYPE_DISABLE 2'h3

// retry setting that never gives up
`define PSFR_RETRY_FOREVER 3'h7

// ----------------------------------------------------------------------
// fault slots, one per action register
// ----------------------------------------------------------------------
`define PSFR_NUM_FAULTS 6
`define PSFR_SLOT_OUT_OV 0
`define PSFR_SLOT_OUT_UV 1
`define PSFR_SLOT_OT 2
`define PSFR_SLOT_LINE_OV 3
`define PSFR_SLOT_LINE_UV 4
`define PSFR_SLOT_LINE_OC 5

// ----------------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------------
`define PSFR_OUTPUT_OVERVOLT_FAULT 7
`define PSFR_OUTPUT_OVERVOLT_WARNING 6
`define PSFR_OUTPUT_UNDERVOLT_WARNING 5
`define PSFR_OUTPUT_UNDERVOLT_FAULT 4
`define PSFR_LINE_OV_FAULT 7
`define PSFR_LINE_UV_WARN 5
`define PSFR_LINE_UV_FAULT 4
`define PSFR_LINE_LOW 3
`define PSFR_LINE_OC_FAULT 2
`define PSFR_LINE_OC_WARN 1
`define PSFR_LINE_OP_WARN 0
`define PSFR_TEMP_OVERTEMP_FAULT 7
`define PSFR_TEMP_OVERTEMP_WARNING 6
`define PSFR_VENDOR_A_CMP_OV 4
`define PSFR_VENDOR_A_OPEN_LOOP 5
`define PSFR_VENDOR_B_FAST_OC 2

// power-good mask bit positions
`define PSFR_PG_UV_FAULT 4
`define PSFR_PG_OV_WARN 3
`define PSFR_PG_CMP_OV 2
`define PSFR_PG_OPEN_LOOP 1
`define PSFR_PG_FAST_OC 0

// ----------------------------------------------------------------------
// timing: debounce and restart delay unit
// ----------------------------------------------------------------------
`define PSFR_CLK_PERIOD_NS 10
`define PSFR_DELAY_UNIT_NS 1000
`define PSFR_DELAY_UNIT_CYCLES (`PSFR_DELAY_UNIT_NS / `PSFR_CLK_PERIOD_NS)

`endif

// ===== testbench/psfr_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// port checker
// ----
module psfr_checker #(
  parameter DELAY_UNIT_CYCLES = 100
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_cmd,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic sw_supply_on_request,
  input wire logic output_overvolt_fault,
  input wire logic line_undervolt_fault,
  input wire logic line_below_turnoff,
  input wire logic line_overpower_warning,
  input wire logic overtemp_warning,
  input wire logic [7:0] vendor_flags_a,
  input wire logic output_ok_pin,
  input wire logic output_enable,
  input wire logic soft_start,
  input wire logic [2:0] fault_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // read answers and summary bits
  property p_rd_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_onreq_off;
    !sw_supply_on_request [*4] ##0 (reg_rd && reg_cmd == 8'h78) |=> reg_rdata[6];
  endproperty
  a_onreq_off: assert property (p_onreq_off) else $error("on request bit low");
  property p_any_ov;
    vendor_flags_a[4] [*3] ##0 (reg_rd && reg_cmd == 8'h78) |=> reg_rdata[5];
  endproperty
  a_any_ov: assert property (p_any_ov) else $error("overvolt summary low");
  property p_line_uv;
    $stable(line_undervolt_fault) [*3] ##0 (reg_rd && reg_cmd == 8'h78)
      |=> reg_rdata[3] == $past(line_undervolt_fault);
  endproperty
  a_line_uv: assert property (p_line_uv) else $error("line uv summary wrong");
  property p_temp;
    overtemp_warning [*3] ##0 (reg_rd && reg_cmd == 8'h78) |=> reg_rdata[2];
  endproperty
  a_temp: assert property (p_temp) else $error("temperature summary low");
  property p_input;
    line_overpower_warning [*3] ##0 (reg_rd && reg_cmd == 8'h79) |=> reg_rdata[13];
  endproperty
  a_input: assert property (p_input) else $error("input summary low");
  // output side responses
  property p_pg;
    output_overvolt_fault [*4] |-> !output_ok_pin;
  endproperty
  a_pg: assert property (p_pg) else $error("power good with overvolt");
  property p_turnoff;
    line_below_turnoff [*4] |-> !output_enable;
  endproperty
  a_turnoff: assert property (p_turnoff) else $error("running below turnoff");
  property p_disabled;
    fault_state == 3'h3 |-> !output_enable && !soft_start;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled state drives");
  property p_ss_pulse;
    soft_start |=> !soft_start;
  endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("soft start too long");
endmodule
bind psfr_status_fault_response psfr_checker #(.DELAY_UNIT_CYCLES(DELAY_UNIT_CYCLES)) chk_u (
  .clk(clk), .resetn(resetn), .reg_cmd(reg_cmd), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .sw_supply_on_request(sw_supply_on_request),
  .output_overvolt_fault(output_overvolt_fault), .line_undervolt_fault(line_undervolt_fault),
  .line_below_turnoff(line_below_turnoff), .line_overpower_warning(line_overpower_warning),
  .overtemp_warning(overtemp_warning), .vendor_flags_a(vendor_flags_a),
  .output_ok_pin(output_ok_pin), .output_enable(output_enable), .soft_start(soft_start),
  .fault_state(fault_state));
`default_nettype wire

// ===== testbench/psfr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// host side of the register port
// ----
module psfr_host_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_cmd,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // idle port, strobes low
  initial begin
    reg_cmd = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write strobe, released lines scrambled
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_cmd = ~c;
    reg_wdata = ~d;
  endtask
  // one read strobe, data taken in the answer cycle
  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    @(posedge clk);
    #1;
    reg_cmd = c;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_cmd = ~c;
    q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_pmbus_status_fault_response.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// testbench
// ----
module test_pmbus_status_fault_response;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic on_pin = 1'b1;
  logic sw_on = 1'b1;
  logic seen_ss = 1'b0;
  logic [15:0] fv = 16'h0000;
  logic [15:0] q;
  logic [7:0] reg_cmd, reg_wdata;
  logic reg_wr, reg_rd, reg_rvalid, output_ok_pin, output_enable, soft_start;
  logic [15:0] reg_rdata;
  logic [2:0] fault_state, active_fault;
  logic [7:0] acts [6] = '{8'h41, 8'h45, 8'h50, 8'h56, 8'h5A, 8'h5C};
  logic [7:0] sts [5] = '{8'h7A, 8'h7C, 8'h7D, 8'h78, 8'h79};
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int i, j;
  // design and host
  psfr_status_fault_response #(.DELAY_UNIT_CYCLES(2)) dut_u (
    .clk(clk), .resetn(resetn), .reg_cmd(reg_cmd), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .supply_on_request(on_pin), .sw_supply_on_request(sw_on),
    .output_overvolt_fault(fv[0]), .output_overvolt_warning(fv[1]),
    .output_undervolt_warning(fv[2]), .output_undervolt_fault(fv[3]),
    .line_overvolt_fault(fv[4]), .line_undervolt_warning(fv[5]),
    .line_undervolt_fault(fv[6]), .line_below_turnoff(fv[7]),
    .line_overcurrent_fault(fv[8]), .line_overcurrent_warning(fv[9]),
    .line_overpower_warning(fv[10]), .overtemp_fault(fv[11]), .overtemp_warning(fv[12]),
    .comm_memory_logic_fault(fv[13]), .vendor_flags_a({3'h0, fv[14], 4'h0}),
    .vendor_flags_b({5'h00, fv[15], 2'h0}), .vendor_flags_c(8'h00),
    .power_good_mask(5'h1F), .output_ok_pin(output_ok_pin), .output_enable(output_enable),
    .soft_start(soft_start), .fault_state(fault_state), .active_fault(active_fault));
  psfr_host_model host_u (.clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // clock and run limit
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict;
    end
  end
  // expected register value for one flag pattern
  function automatic logic [15:0] exp_of(input logic [7:0] c, input logic [15:0] f);
    logic [7:0] sb;
    sb = {2'h0, f[0] | f[14], 1'b0, f[6], f[11] | f[12], f[13],
          |{f[5:1], f[10:7], f[15:14]}};
    case (c)
      8'h7A: exp_of = {8'h00, f[0], f[1], f[2], f[3], 4'h0};
      8'h7C: exp_of = {8'h00, f[4], 1'b0, f[5], f[6], f[7], f[8], f[9], f[10]};
      8'h7D: exp_of = {8'h00, f[11], f[12], 6'h00};
      8'h78: exp_of = {8'h00, sb};
      default: exp_of = {|f[3:0] | f[14], 1'b0, |f[10:4], f[14] | f[15],
                         f[0] | f[1] | f[3] | f[14] | f[15], 3'h0, sb};
    endcase
  endfunction
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR time %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // wait for an engine state
  task automatic wait_state(input logic [2:0] s);
    int n;
    seen_ss = 1'b0;
    for (n = 0; n < 300 && fault_state !== s; n++) begin
      tick(1);
      seen_ss = seen_ss | soft_start;
    end
    chk(16'(fault_state), 16'(s));
  endtask
  // one programmed fault response
  task automatic fault_case(input logic [7:0] c0, d0, c1, d1, input logic [15:0] f,
                            input logic [2:0] st, af, input logic ss);
    host_u.wr(c0, d0);
    host_u.wr(c1, d1);
    fv = f;
    wait_state(st);
    chk(16'(active_fault), 16'(af));
    chk(16'(output_enable), 16'h0000);
    fv = 16'h0000;
    if (st == 3'h4) begin
      sw_on = 1'b0;
      tick(4);
      sw_on = 1'b1;
    end
    wait_state(3'h1);
    chk(16'(seen_ss), 16'(ss));
    host_u.wr(c0, 8'h00);
    host_u.wr(c1, 8'h00);
    $display("fault case done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    tick(16);
    resetn = 1'b1;
    tick(3);
    wait_state(3'h1);
    for (i = 0; i < 6; i++) begin
      host_u.rd(acts[i], q);
      chk(q, 16'h0000);
      host_u.wr(acts[i], 8'h38 + i[7:0]);
      host_u.rd(acts[i], q);
      chk(q, {8'h00, 8'h38 + i[7:0]});
      host_u.wr(acts[i], 8'h00);
    end
    host_u.rd(8'h00, q);
    chk(q, 16'h0000);
    host_u.wr(8'h7D, 8'hFF);
    host_u.rd(8'h7D, q);
    chk(q, 16'h0000);
    $display("registers done");
    for (i = 0; i < 16; i++) begin
      fv = 16'h0001 << i;
      tick(3);
      for (j = 0; j < 5; j++) begin
        host_u.rd(sts[j], q);
        chk(q, exp_of(sts[j], fv));
      end
      q = exp_of(8'h79, fv);
      chk(16'(output_ok_pin), {15'h0000, ~q[11]});
    end
    fv = 16'h0000;
    wait_state(3'h1);
    $display("flags done");
    sw_on = 1'b0;
    tick(5);
    host_u.rd(8'h78, q);
    chk(16'(q[6]), 16'h0001);
    sw_on = 1'b1;
    wait_state(3'h1);
    $display("on request done");
    fault_case(8'h50, 8'h80, 8'h50, 8'h80, 16'h0800, 3'h4, 3'h2, 1'b1);
    fault_case(8'h50, 8'h8A, 8'h50, 8'h8A, 16'h0800, 3'h2, 3'h2, 1'b1);
    fault_case(8'h45, 8'hC0, 8'h45, 8'hC0, 16'h0008, 3'h3, 3'h1, 1'b0);
    fault_case(8'h41, 8'h40, 8'h5C, 8'hC0, 16'h0101, 3'h3, 3'h5, 1'b0);
    fault_case(8'h50, 8'h98, 8'h56, 8'h88, 16'h0810, 3'h2, 3'h3, 1'b1);
    host_u.wr(8'h50, 8'h43);
    fv = 16'h0800;
    tick(3);
    fv = 16'h0000;
    tick(8);
    chk(16'(output_enable), 16'h0001);
    fault_case(8'h50, 8'h43, 8'h50, 8'h43, 16'h0800, 3'h2, 3'h2, 1'b1);
    fv = 16'h0800;
    tick(10);
    chk(16'({fault_state, output_enable}), 16'h0003);
    fv = 16'h0000;
    $display("engine done");
    give_verdict;
  end
endmodule
`default_nettype wire
